// ---- design/dscd_top.sv ----
// command decoder for a 16-channel dac behind a 24-bit serial link
`timescale 1ns/1ns
module dscd_top
    import dscd_pkg::*;
#(
    parameter int DATA_BITS = 16
)(
    input  wire logic     MCLK,        // core clock, 10 MHz
    input  wire logic     RST_B,       // async reset, active low
    input  wire logic     SCLK,        // serial link clock
    input  wire logic     SYNC_B,      // frame select, active low
    input  wire logic     SDI,         // serial data in
    output logic          SDO,         // serial data out
    output logic          SDO_OE_B,    // low while SDO driven
    output dscd_pkg::dscd_code_arr_t DAC_CODE, // dac register per channel
    output logic          CLAMP,       // outputs held at ground
    output logic [2:0]    SPAN,        // output span code
    output logic [1:0]    PWRUP_LEVEL, // power-up level code
    output logic          MON_EN,      // monitor mux routes a channel
    output logic [3:0]    MON_CH,      // monitor mux channel
    output logic [15:0]   DITHER_PD,   // dither power-down per channel
    output logic          CMD_DONE     // pulse: frame decoded
);
    import dscd_pkg::*;

    if (DATA_BITS != 16 && DATA_BITS != 12) begin : g_bad_width
        $error("DATA_BITS must be 12 or 16");
    end

    localparam logic [15:0] DMASK = (DATA_BITS == 12) ? MASK_12BIT : MASK_16BIT;

    typedef struct packed {
        dscd_code_arr_t in_reg;
        dscd_code_arr_t dac;
        logic [4:0]     mon_sel;
        logic           chain_en;
        logic [2:0]     span;
        logic [1:0]     pwrup;
        logic [15:0]    dpd;
        logic           clamp;
        logic           sync1;
        logic           sync2;
        logic           seen;
        logic           done;
    } dscd_top_st_t;

    function automatic dscd_top_st_t rst_state();
        dscd_top_st_t s;
        s          = '0;
        s.in_reg   = {NUM_CH{CODE_RST}};
        s.dac      = {NUM_CH{CODE_RST}};
        s.mon_sel  = MON_SEL_RST;
        s.chain_en = CHAIN_EN_RST;
        s.span     = SPAN_RST;
        s.pwrup    = PWRUP_RST;
        s.dpd      = DITHER_PD_RST;
        s.clamp    = CLAMP_RST;
        return s;
    endfunction

    localparam dscd_top_st_t ST_RST = rst_state();

    dscd_top_st_t   q;
    dscd_top_st_t   d;
    dscd_frame_t    frame;
    logic           frame_tgl;
    dscd_link_cfg_t link_cfg;
    logic [15:0]    data;
    logic [15:0]    level;

    assign link_cfg = '{chain_en: q.chain_en, span: q.span};

    dscd_link u_link (
        .sclk      (SCLK),
        .rst_b     (RST_B),
        .sync_b    (SYNC_B),
        .sdi       (SDI),
        .cfg       (link_cfg),
        .frame     (frame),
        .frame_tgl (frame_tgl),
        .sdo       (SDO),
        .sdo_oe_b  (SDO_OE_B)
    );

    always_comb begin
        d       = q;
        d.done  = 1'b0;
        d.sync1 = frame_tgl;
        d.sync2 = q.sync1;
        d.seen  = q.sync2;
        data    = frame.data & DMASK;
        if (frame.data[PWRUP_LSB + PWRUP_HI_BIT]) begin
            level = CODE_FULL;
        end else if (frame.data[PWRUP_LSB]) begin
            level = CODE_MID;
        end else begin
            level = CODE_ZERO;
        end
        level = level & DMASK;
        // frame word stays put for a whole frame after the toggle
        if (q.sync2 != q.seen) begin
            d.done = 1'b1;
            case (frame.cmd)
                CMD_MISC: begin
                    if (frame.addr == ADDR_MON) begin
                        // all-zero frame is the no-operation
                        if (frame.data != 16'h0000) begin
                            d.mon_sel = frame.data[MON_SEL_LSB +: 5];
                        end
                    end else if (frame.addr == ADDR_CHAIN) begin
                        d.chain_en = frame.data[CHAIN_EN_BIT];
                    end
                end
                CMD_WR_IN: begin
                    d.in_reg[frame.addr] = data;
                end
                CMD_WR_DAC: begin
                    d.in_reg[frame.addr] = data;
                    d.dac[frame.addr]    = data;
                end
                CMD_LOAD: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (frame.data[i]) begin
                            d.dac[i] = q.in_reg[i];
                        end
                    end
                end
                CMD_SPAN: begin
                    d.span   = frame.data[SPAN_LSB +: 3];
                    d.pwrup  = frame.data[PWRUP_LSB +: 2];
                    d.clamp  = 1'b0;
                    d.in_reg = {NUM_CH{level}};
                    d.dac    = {NUM_CH{level}};
                end
                CMD_DITHER: begin
                    if (frame.addr == ADDR_DITHER_PD) begin
                        d.dpd = frame.data;
                    end
                end
                CMD_ALL: begin
                    d.in_reg = {NUM_CH{data}};
                    d.dac    = {NUM_CH{data}};
                end
                CMD_RESET: begin
                    if (frame.addr == ADDR_RESET && frame.data == RESET_KEY) begin
                        d       = ST_RST;
                        d.sync1 = q.sync1;
                        d.sync2 = q.sync2;
                        d.seen  = q.sync2;
                        d.done  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign DAC_CODE    = q.dac;
    assign CLAMP       = q.clamp;
    assign SPAN        = q.span;
    assign PWRUP_LEVEL = q.pwrup;
    assign MON_EN      = q.mon_sel[MON_EN_BIT];
    assign MON_CH      = q.mon_sel[3:0];
    assign DITHER_PD   = q.dpd;
    assign CMD_DONE    = q.done;
endmodule

// ---- design/dscd_pkg.sv ----
// constants and carrier types of the serial command decoder
// Operation
// - upper byte zero selects monitor mux command
// - bit 4 enables mux, low four pick channel
// - all-zero frame changes nothing
// - upper byte one loads chain output enable
// - chain output enable clears on reset
// - code 0001 writes addressed input register only
// - 12-bit variant ignores four lowest bits of dac codes
// - code 0010 writes input and dac register
// - code 0011 copies masked input registers to dac
// - code 0100 loads three-bit span code
// - span command loads two-bit power-up level
// - code 0101 address 0001 loads dither power-down
// - dither power-down bits clear on reset
// - code 0110 writes every channel at once
// - address bits select channel in plain binary
// - reset command with key restores power-on state
// - outputs clamped until span write
// - 24-bit frames, readback shifts out next frame
package dscd_pkg;

    localparam int NUM_CH     = 16;
    localparam int CODE_W     = 16;
    localparam int FRAME_BITS = 24;

    localparam logic [3:0] CMD_MISC     = 4'h0;
    localparam logic [3:0] CMD_WR_IN    = 4'h1;
    localparam logic [3:0] CMD_WR_DAC   = 4'h2;
    localparam logic [3:0] CMD_LOAD     = 4'h3;
    localparam logic [3:0] CMD_SPAN     = 4'h4;
    localparam logic [3:0] CMD_DITHER   = 4'h5;
    localparam logic [3:0] CMD_ALL      = 4'h6;
    localparam logic [3:0] CMD_RESET    = 4'h7;
    localparam logic [3:0] CMD_READBACK = 4'h8;

    localparam logic [3:0]  ADDR_MON       = 4'h0;
    localparam logic [3:0]  ADDR_CHAIN     = 4'h1;
    localparam logic [3:0]  ADDR_DITHER_PD = 4'h1;
    localparam logic [3:0]  ADDR_RESET     = 4'h0;
    localparam logic [15:0] RESET_KEY      = 16'h1234;

    // field positions inside the 16-bit data field
    localparam int MON_SEL_LSB  = 0;
    localparam int MON_EN_BIT   = 4;
    localparam int CHAIN_EN_BIT = 0;
    localparam int SPAN_LSB     = 0;
    localparam int PWRUP_LSB    = 3;
    localparam int PWRUP_HI_BIT = 1;

    localparam logic [15:0] MASK_16BIT = 16'hffff;
    localparam logic [15:0] MASK_12BIT = 16'hfff0;

    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID  = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hffff;

    localparam logic [4:0]  MON_SEL_RST   = 5'h00;
    localparam logic        CHAIN_EN_RST  = 1'b0;
    localparam logic [2:0]  SPAN_RST      = 3'h0;
    localparam logic [1:0]  PWRUP_RST     = 2'h0;
    localparam logic [15:0] DITHER_PD_RST = 16'h0000;
    localparam logic        CLAMP_RST     = 1'b1;
    localparam logic [15:0] CODE_RST      = 16'h0000;
    localparam logic [12:0] RB_PAD        = 13'h0000;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } dscd_frame_t;

    typedef struct packed {
        logic       chain_en;
        logic [2:0] span;
    } dscd_link_cfg_t;

    typedef logic [NUM_CH-1:0][CODE_W-1:0] dscd_code_arr_t;

endpackage

// ---- design/dscd_link.sv ----
// serial-clock side: frame shifter, readback load and chain output
`timescale 1ns/1ns
module dscd_link
    import dscd_pkg::*;
(
    input  wire logic           sclk,      // serial link clock
    input  wire logic           rst_b,     // async reset, active low
    input  wire logic           sync_b,    // frame select, active low
    input  wire logic           sdi,       // serial data in
    input  wire dscd_pkg::dscd_link_cfg_t cfg,   // settings from main clock domain
    output dscd_pkg::dscd_frame_t         frame, // last complete frame
    output logic                frame_tgl, // toggles once per frame
    output logic                sdo,       // serial data out
    output logic                sdo_oe_b   // low while sdo is driven
);
    typedef struct packed {
        logic [4:0]     cnt;
        logic [23:0]    sh;
        dscd_frame_t    word;
        logic           tgl;
        dscd_link_cfg_t cfg_m;
        dscd_link_cfg_t cfg_s;
    } dscd_link_st_t;

    dscd_link_st_t q;
    dscd_link_st_t d;
    logic [23:0]   shifted;

    always_comb begin
        d       = q;
        shifted = {q.sh[22:0], sdi};
        // cfg is quasi-static, set frames before it matters
        d.cfg_m = cfg;
        d.cfg_s = q.cfg_m;
        if (!sync_b) begin
            d.sh = shifted;
            if (q.cnt == 5'(FRAME_BITS - 1)) begin
                d.cnt  = 5'h00;
                d.word = dscd_frame_t'(shifted);
                d.tgl  = ~q.tgl;
                if (shifted[23:20] == CMD_READBACK) begin
                    d.sh = {CMD_READBACK, shifted[19:16], RB_PAD, q.cfg_s.span};
                end
            end else begin
                d.cnt = q.cnt + 5'h01;
            end
        end
    end

    // no reset from sync_b: clock stops outside frames, so the count wraps
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign frame     = q.word;
    assign frame_tgl = q.tgl;
    assign sdo       = q.sh[23];
    assign sdo_oe_b  = ~q.cfg_s.chain_en;
endmodule

// ---- dv/dscd_host.sv ----
// host model driving the serial command link
`timescale 1ns/1ns
module dscd_host (
    output logic        sclk,   // link clock, idle low
    output logic        sync_b, // frame select, active low
    output logic        sdi,    // serial data
    input  wire logic   sdo,    // serial data back from the decoder
    output logic [23:0] rx      // bits seen on sdo during the last frame
);
    initial begin
        sclk   = 1'b0;
        sync_b = 1'b1;
        sdi    = 1'b0;
    end
    // 15 ns link clock, runs only inside a frame
    task automatic send(input logic [23:0] f);
        sync_b = 1'b0;
        #3;
        for (int k = 23; k >= 0; k--) begin
            sdi = f[k];
            #7;
            // sdo moves just after a rise, so take it before the next one
            rx[k] = sdo;
            sclk = 1'b1;
            #8 sclk = 1'b0;
        end
        // released line flips, so a stale bit is never read as valid
        sdi = ~f[0];
        #5 sync_b = 1'b1;
    endtask
endmodule

// ---- dv/dscd_asserts.sv ----
// concurrent checks on the decoder outputs
`timescale 1ns/1ns
module dscd_asserts
    import dscd_pkg::*;
#(
    parameter int DATA_BITS = 16
)(
    input wire logic           MCLK,        // core clock
    input wire logic           RST_B,       // async reset
    input wire dscd_code_arr_t DAC_CODE,    // dac registers
    input wire logic           CLAMP,       // output clamp
    input wire logic [2:0]     SPAN,        // span code
    input wire logic [1:0]     PWRUP_LEVEL, // power-up level
    input wire logic           MON_EN,      // mux enable
    input wire logic [3:0]     MON_CH,      // mux channel
    input wire logic [15:0]    DITHER_PD,   // dither power-down
    input wire logic           CMD_DONE     // frame decoded
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic [15:0] lvl;
    logic        all_lvl;
    assign lvl = (PWRUP_LEVEL[1] ? CODE_FULL : (PWRUP_LEVEL[0] ? CODE_MID : CODE_ZERO))
                 & ((DATA_BITS == 12) ? MASK_12BIT : MASK_16BIT);
    assign all_lvl = (DAC_CODE == {NUM_CH{lvl}});
    sequence quiet4;
        !CMD_DONE [*4];
    endsequence
    a_done_space: assert property (CMD_DONE |=> quiet4)
        else $error("decode pulses too close");
    a_idle_hold: assert property (!CMD_DONE |-> $stable(DAC_CODE) && $stable(SPAN)
        && $stable(CLAMP) && $stable(PWRUP_LEVEL)) else $error("output moved without a frame");
    a_mon_cause: assert property (($changed(MON_EN) || $changed(MON_CH)) |-> CMD_DONE)
        else $error("monitor select moved without a frame");
    a_dither_cause: assert property ($changed(DITHER_PD) |-> CMD_DONE)
        else $error("dither power-down moved without a frame");
    a_clamp_fell: assert property ($fell(CLAMP) |-> CMD_DONE && all_lvl)
        else $error("unclamp without power-up level");
    a_clamp_rose: assert property ($rose(CLAMP) |-> CMD_DONE && DAC_CODE == '0)
        else $error("reclamp with nonzero codes");
    a_rst_cfg: assert property ($rose(CLAMP) |-> SPAN == SPAN_RST && !MON_EN
        && DITHER_PD == DITHER_PD_RST) else $error("soft reset left settings");
    a_span_unclamp: assert property (!CLAMP && $changed(SPAN) |-> $fell(CLAMP))
        else $error("span changed apart from unclamp");
endmodule

// ---- dv/tb_top.sv ----
// testbench: serial command frames against the decoder outputs
`timescale 1ns/1ns
module tb_top;
    import dscd_pkg::*;
    logic           mclk, rst_b, sclk, sync_b, sdi, sdo, sdo_oe_b;
    logic           clamp, mon_en, cmd_done;
    logic [2:0]     span;
    logic [1:0]     pwrup;
    logic [3:0]     mon_ch;
    logic [15:0]    dith;
    logic [23:0]    rx;
    dscd_code_arr_t dac;
    dscd_code_arr_t dac12;
    int             error_cnt = 0;
    int             total_checks = 0;
    int             cyc = 0;
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    dscd_host host_u (.sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo), .rx(rx));
    dscd_top #(.DATA_BITS(16)) dut_u (
        .MCLK(mclk), .RST_B(rst_b), .SCLK(sclk), .SYNC_B(sync_b), .SDI(sdi),
        .SDO(sdo), .SDO_OE_B(sdo_oe_b), .DAC_CODE(dac), .CLAMP(clamp), .SPAN(span),
        .PWRUP_LEVEL(pwrup), .MON_EN(mon_en), .MON_CH(mon_ch), .DITHER_PD(dith),
        .CMD_DONE(cmd_done));
    // 12-bit variant on the same link; only its dac registers are compared
    dscd_top #(.DATA_BITS(12)) dut12_u (
        .MCLK(mclk), .RST_B(rst_b), .SCLK(sclk), .SYNC_B(sync_b), .SDI(sdi),
        .SDO(), .SDO_OE_B(), .DAC_CODE(dac12), .CLAMP(), .SPAN(), .PWRUP_LEVEL(),
        .MON_EN(), .MON_CH(), .DITHER_PD(), .CMD_DONE());
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one frame, then wait for its decode pulse
    task automatic cmd(input logic [23:0] f);
        int n;
        @(posedge mclk);
        #2;
        host_u.send(f);
        n = 0;
        while (cmd_done !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #2;
            n++;
        end
        chk(cmd_done, 1'b1);
    endtask
    function automatic logic [15:0] lvl(input logic [1:0] p);
        return p[1] ? CODE_FULL : (p[0] ? CODE_MID : CODE_ZERO);
    endfunction
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        rst_b = 1'b0;
        repeat (20) @(posedge mclk);
        #2 rst_b = 1'b1;
        chk(clamp, 1'b1);
        chk(sdo_oe_b, 1'b1);
        chk(dith, 16'h0000);
        for (int s = 0; s < 8; s++) begin
            cmd(24'h70_1234);
            chk(clamp, 1'b1);
            cmd({8'h40, 11'h000, s[1:0], s[2:0]});
            chk(span, s[2:0]);
            chk(pwrup, s[1:0]);
            chk(dac, {NUM_CH{lvl(s[1:0])}});
            chk(dac12, {NUM_CH{lvl(s[1:0]) & MASK_12BIT}});
            chk(clamp, 1'b0);
        end
        cmd(24'h1F_ABCD);
        chk(dac[15], 16'hFFFF);
        cmd(24'h13_1230);
        cmd(24'h10_0001);
        cmd(24'h30_8008);
        chk(dac[15], 16'hABCD);
        chk(dac12[15], 16'hABC0);
        chk(dac[3], 16'h1230);
        chk(dac[0], 16'hFFFF);
        cmd(24'h2A_5555);
        chk(dac[10], 16'h5555);
        chk(dac[11], 16'hFFFF);
        cmd(24'h6B_0F0F);
        chk(dac, {NUM_CH{16'h0F0F}});
        chk(dac12, {NUM_CH{16'h0F00}});
        cmd(24'h00_0017);
        chk({mon_en, mon_ch}, 5'h17);
        cmd(24'h00_0020);
        chk(mon_en, 1'b0);
        cmd(24'h00_0000);
        chk(dac, {NUM_CH{16'h0F0F}});
        cmd(24'h51_A5A5);
        chk(dith, 16'hA5A5);
        cmd(24'h50_FFFF);
        chk(dith, 16'hA5A5);
        cmd(24'h01_0001);
        cmd(24'h00_0000);
        chk(sdo_oe_b, 1'b0);
        cmd(24'h85_0000);
        cmd(24'h00_0020);
        chk(rx, 24'h85_0007);
        cmd(24'h00_0000);
        chk(rx, 24'h00_0020);
        cmd(24'h01_0000);
        cmd(24'h00_0000);
        chk(sdo_oe_b, 1'b1);
        cmd(24'h70_1234);
        chk(dac, '0);
        chk({dith, mon_en, span}, 20'h0_0000);
        chk(clamp, 1'b1);
        // settings set again, then a pin reset in mid-run must clear them
        cmd(24'h51_00FF);
        cmd(24'h01_0001);
        cmd(24'h00_0000);
        chk({dith, sdo_oe_b}, 17'h0_01FE);
        @(posedge mclk);
        #2 rst_b = 1'b0;
        repeat (3) @(posedge mclk);
        #2 rst_b = 1'b1;
        chk(sdo_oe_b, 1'b1);
        chk(dith, 16'h0000);
        chk(clamp, 1'b1);
        cmd(24'h00_0000);
        chk(sdo_oe_b, 1'b1);
        close_out();
    end
endmodule
bind dscd_top dscd_asserts #(.DATA_BITS(DATA_BITS)) chk_u (
    .MCLK(MCLK), .RST_B(RST_B), .DAC_CODE(DAC_CODE), .CLAMP(CLAMP), .SPAN(SPAN),
    .PWRUP_LEVEL(PWRUP_LEVEL), .MON_EN(MON_EN), .MON_CH(MON_CH),
    .DITHER_PD(DITHER_PD), .CMD_DONE(CMD_DONE));
